// >>> bench/core_model.sv
// behavioural memory core standing behind the decoder
// assumes lane strobes and core address settle before each clock edge
`timescale 1ns/10ps
`default_nettype none
module core_model
    import burst_sram_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic [ADDR_WIDTH-1:0] core_addr,
    input  wire logic [LANE_COUNT-1:0] lane_write,
    input  wire logic [DATA_WIDTH-1:0] write_data,
    output logic      [DATA_WIDTH-1:0] core_rdata
);
    // small window of words; preset so reads never return unknowns
    logic [DATA_WIDTH-1:0] mem [16] = '{default: 36'hA5A5A5A5A};

    // a lane strobe stores its data byte and parity bit together
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < LANE_COUNT; i++) begin
            if (lane_write[i]) begin
                mem[core_addr[3:0]][i*LANE_WIDTH+:LANE_WIDTH] <=
                    write_data[i*LANE_WIDTH+:LANE_WIDTH];
            end
        end
    end

    // flow-through read of the addressed word
    assign core_rdata = mem[core_addr[3:0]];
endmodule
`default_nettype wire

// >>> bench/sram_decode_properties.sv
// port assertions for the burst sram cycle decoder
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module sram_decode_properties
    import burst_sram_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst_b,
    input wire logic                  select_low_first,
    input wire logic                  select_high_second,
    input wire logic                  select_low_third,
    input wire logic                  sleep_request,
    input wire logic                  processor_addr_strobe,
    input wire logic                  controller_addr_strobe,
    input wire logic                  burst_advance,
    input wire logic                  global_write_n,
    input wire logic                  byte_write_gate_n,
    input wire logic [LANE_COUNT-1:0] byte_select_n,
    input wire logic                  output_enable_n,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic                  data_oe_n,
    input wire logic [ADDR_WIDTH-1:0] core_addr,
    input wire logic [LANE_COUNT-1:0] lane_write,
    input wire logic                  core_read,
    input wire logic [2:0]            cycle_state,
    input wire logic                  asleep
);
    logic                  wr, sel, awake, live, go, des;
    logic [LANE_COUNT-1:0] lanes;

    // expected decode worked out from the pins
    assign wr = !global_write_n ||
                (!byte_write_gate_n && !(&byte_select_n));
    assign lanes = !global_write_n ? 4'hF
                 : (byte_write_gate_n ? 4'h0 : ~byte_select_n);
    assign sel = !select_low_first && select_high_second &&
                 !select_low_third;
    assign awake = !sleep_request && !asleep;
    assign live = cycle_state >= 3'h3;
    assign go = controller_addr_strobe &&
                (processor_addr_strobe || select_low_first);
    // strobe from an unselected device is never a begin
    assign des = select_low_first ? !controller_addr_strobe
               : !sel && !(processor_addr_strobe && controller_addr_strobe);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_deselect_cycle: assert property (
        awake && des |=> cycle_state == CYC_DESELECT)
        else $error("deselect not decoded");
    a_proc_begin: assert property (
        awake && sel && !processor_addr_strobe |=> cycle_state == CYC_BEGIN
        && core_read && lane_write == 4'h0 && core_addr == $past(addr))
        else $error("processor strobe read not begun");
    a_ctrl_begin: assert property (
        awake && sel && processor_addr_strobe && !controller_addr_strobe
        |=> cycle_state == CYC_BEGIN && lane_write == $past(lanes)
        && core_read == !$past(wr) && core_addr == $past(addr))
        else $error("controller strobe begin wrong");
    a_suspend_hold: assert property (
        awake && live && go && burst_advance |=> cycle_state == CYC_SUSPEND
        && $stable(core_addr) && lane_write == $past(lanes))
        else $error("suspend moved or wrote wrong lanes");
    a_continue_step: assert property (
        awake && live && go && !burst_advance |=>
        cycle_state == CYC_CONTINUE && lane_write == $past(lanes)
        && ((core_addr ^ $past(core_addr)) >> BURST_BITS) == '0
        && ((core_addr ^ $past(core_addr)) & ADDR_WIDTH'(3)) != '0)
        else $error("continue did not step low bits only");
    a_sleep_float: assert property (sleep_request |-> data_oe_n)
        else $error("pins driven while sleep requested");
    a_read_float: assert property (
        output_enable_n || !core_read |-> data_oe_n)
        else $error("pins driven without read and enable");
    a_write_mask: assert property (|lane_write |-> data_oe_n)
        else $error("pins driven during write");
    a_read_drive: assert property (
        core_read && !output_enable_n && !sleep_request |-> !data_oe_n)
        else $error("read with enable not driven");
    a_sleep_entry: assert property (
        $rose(sleep_request) |-> ##[1:8] asleep)
        else $error("sleep state not reached");
endmodule
bind sync_burst_sram_cycle_decode sram_decode_properties chk (.*);
`default_nettype wire

// >>> bench/tb_sync_burst_sram_cycle_decode.sv
// self-checking bench for the burst sram cycle decoder
// assumes the core model answers reads; no registers or interrupts
`timescale 1ns/10ps
`default_nettype none
module tb_sync_burst_sram_cycle_decode;
    import burst_sram_pkg::*;
    typedef struct packed {
        logic [2:0]            st;
        logic [LANE_COUNT-1:0] ln;
        logic [ADDR_WIDTH-1:0] ad;
        logic                  oe;
        logic [DATA_WIDTH-1:0] dt;
    } note_type;
    logic sys_clk, rst_b, select_low_first, select_high_second;
    logic select_low_third, sleep_request, processor_addr_strobe;
    logic controller_addr_strobe, burst_advance, global_write_n;
    logic byte_write_gate_n, output_enable_n, burst_order;
    logic core_read, data_oe_n, asleep;
    logic [LANE_COUNT-1:0] byte_select_n, lane_write;
    logic [ADDR_WIDTH-1:0] addr, core_addr;
    logic [ADDR_WIDTH-3:0] base;
    logic [DATA_WIDTH-1:0] data_in, data_out, write_data, core_rdata;
    logic [2:0]            cycle_state;
    note_type              q[$];
    int                    fails, check_count;
    // control words {sel1, sel2, sel3, proc strobe, ctrl strobe, advance}
    localparam logic [5:0] PROC = 6'h12, CTRL = 6'h14;
    localparam logic [5:0] NEXT = 6'h36, HOLD = 6'h37;
    localparam logic [5:0] DES [4] = '{6'h34, 6'h02, 6'h1A, 6'h04};

    sync_burst_sram_cycle_decode dut (.*);
    core_model core (.*);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [DATA_WIDTH-1:0] e,
                       input logic [DATA_WIDTH-1:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus cycle at the falling edge; write word is {gw, gate, lanes}
    task automatic cyc(input logic [5:0] c, input logic [5:0] w,
                       input logic [2:0] es, input logic [1:0] lo);
        note_type n;
        @(negedge sys_clk);
        {select_low_first, select_high_second, select_low_third,
         processor_addr_strobe, controller_addr_strobe, burst_advance} = c;
        {global_write_n, byte_write_gate_n, byte_select_n} = w;
        output_enable_n = 1'($urandom);
        data_in = DATA_WIDTH'({$urandom, $urandom});
        addr = ADDR_WIDTH'($urandom);
        if (es == CYC_BEGIN) begin
            addr[1:0] = lo;
            base = addr[ADDR_WIDTH-1:2];
        end
        n.st = es;
        n.ln = (es < 3'h3 || (es == CYC_BEGIN && !c[2])) ? 4'h0
             : (!w[5] ? 4'hF : (w[4] ? 4'h0 : ~w[3:0]));
        // master floats its enable before any write cycle begins
        if (n.ln != 4'h0) output_enable_n = 1'b1;
        n.ad = {base, lo};
        n.oe = !(es >= 3'h3 && n.ln == 4'h0 && !output_enable_n);
        n.dt = data_in;
        q.push_back(n);
    endtask

    // oldest note against what the decoder produced after the edge
    always @(posedge sys_clk) begin
        note_type              n;
        logic [DATA_WIDTH-1:0] rd;
        // core word ahead of the edge; read data is held one cycle
        rd = core_rdata;
        #1;
        if (q.size() > 0) begin
            n = q.pop_front();
            chk("cycle", n.st, cycle_state);
            chk("rdata", rd, data_out);
            chk("read", (n.st >= 3'h3 && n.ln == 4'h0), core_read);
            chk("oe", n.oe, data_oe_n);
            if (n.st >= 3'h3) begin
                chk("addr", n.ad, core_addr);
                chk("lanes", n.ln, lane_write);
                if (n.ln != 4'h0) chk("wdata", n.dt, write_data);
            end
        end
    end

    task automatic finish_test(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // a hang is cut at 10000 cycles, well past the sixty or so cycles the tests need
    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        int k;
        {rst_b, sleep_request, burst_order, output_enable_n} = 4'h1;
        {select_low_first, select_high_second, select_low_third} = 3'h6;
        {processor_addr_strobe, controller_addr_strobe} = 2'h3;
        {burst_advance, global_write_n, byte_write_gate_n} = 3'h7;
        {byte_select_n, addr, data_in, base} = '1;
        {fails, check_count} = '0;
        void'($urandom(78735));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) cyc(DES[i], 6'h3F, CYC_DESELECT, 2'h0);
        cyc(NEXT, 6'h3F, CYC_IDLE, 2'h0);
        finish_test("deselect");
        cyc(PROC, 6'h1F, CYC_BEGIN, 2'h3);
        cyc(NEXT, 6'h3F, CYC_CONTINUE, 2'h0);
        cyc(6'h32, 6'h1F, CYC_CONTINUE, 2'h1);
        cyc(HOLD, 6'h1F, CYC_SUSPEND, 2'h1);
        cyc(HOLD, 6'h3F, CYC_SUSPEND, 2'h1);
        cyc(NEXT, 6'h3F, CYC_CONTINUE, 2'h2);
        finish_test("linear burst");
        for (int i = 0; i < 16; i++) cyc(CTRL, 6'h20 | 6'(i), CYC_BEGIN, 2'($urandom));
        cyc(CTRL, 6'h1A, CYC_BEGIN, 2'h0);
        cyc(CTRL, 6'h30, CYC_BEGIN, 2'h1);
        finish_test("lane writes");
        burst_order = 1'b1;
        repeat (3) cyc(DES[0], 6'h3F, CYC_DESELECT, 2'h0);
        cyc(6'h10, 6'h3F, CYC_BEGIN, 2'h2);
        cyc(NEXT, 6'h3F, CYC_CONTINUE, 2'h3);
        cyc(NEXT, 6'h1F, CYC_CONTINUE, 2'h0);
        cyc(NEXT, 6'h3F, CYC_CONTINUE, 2'h1);
        finish_test("interleaved burst");
        cyc(DES[0], 6'h3F, CYC_DESELECT, 2'h0);
        @(negedge sys_clk);
        sleep_request = 1'b1;
        output_enable_n = 1'b0;
        #1;
        chk("sleep float", 1, data_oe_n);
        for (k = 0; k < 10 && asleep !== 1'b1; k++) @(posedge sys_clk) #1;
        chk("asleep", 1, asleep);
        @(negedge sys_clk);
        sleep_request = 1'b0;
        {select_low_first, processor_addr_strobe} = 2'h3;
        controller_addr_strobe = 1'b1;
        for (k = 0; k < 10 && asleep !== 1'b0; k++) @(posedge sys_clk) #1;
        chk("awake", 0, asleep);
        cyc(PROC, 6'h3F, CYC_BEGIN, 2'h0);
        finish_test("sleep");
        repeat (2) @(posedge sys_clk);
        summarize();
    end
endmodule
`default_nettype wire

// >>> hw/burst_sequencer.sv
// two-bit burst counter and address sequencer
// assumes inputs already synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module burst_sequencer
    import burst_sram_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic                  load,
    input  wire logic                  step,
    input  wire logic                  interleave,
    input  wire logic [BURST_BITS-1:0] start_bits,
    output logic      [BURST_BITS-1:0] burst_bits
);
    logic [BURST_BITS-1:0] start_reg;
    logic [BURST_BITS-1:0] count_reg;

    // --------------------------------------------------------------
    // counter
    // --------------------------------------------------------------
    // load captures the first address; step wraps modulo four
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_reg <= COUNT_RESET;
            count_reg <= COUNT_RESET;
        end else if (load) begin
            start_reg <= start_bits;
            count_reg <= COUNT_RESET;
        end else if (step) begin
            count_reg <= count_reg + 2'h1;
        end
    end

    // interleaved order xors the step count, linear adds it
    assign burst_bits = interleave ? (start_reg ^ count_reg)
                                   : (start_reg + count_reg);
endmodule
`default_nettype wire

// >>> hw/sync_burst_sram_cycle_decode.sv
// cycle decoder and data-port control for a flow-through burst sram
// assumes a bus master on sys_clk; sleep and output enable are async pins
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_cycle_decode
    import burst_sram_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic                  select_low_first,
    input  wire logic                  select_high_second,
    input  wire logic                  select_low_third,
    input  wire logic                  sleep_request,
    input  wire logic                  processor_addr_strobe,
    input  wire logic                  controller_addr_strobe,
    input  wire logic                  burst_advance,
    input  wire logic                  global_write_n,
    input  wire logic                  byte_write_gate_n,
    input  wire logic [LANE_COUNT-1:0] byte_select_n,
    input  wire logic                  output_enable_n,
    input  wire logic                  burst_order,
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic [DATA_WIDTH-1:0] data_in,
    output logic      [DATA_WIDTH-1:0] data_out,
    output logic                       data_oe_n,
    output logic      [ADDR_WIDTH-1:0] core_addr,
    output logic      [LANE_COUNT-1:0] lane_write,
    output logic      [DATA_WIDTH-1:0] write_data,
    output logic                       core_read,
    input  wire logic [DATA_WIDTH-1:0] core_rdata,
    output logic      [2:0]            cycle_state,
    output logic                       asleep
);
    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic sleep_meta_reg;
    logic sleep_sync_reg;
    logic oe_meta_reg;
    logic oe_sync_reg;
    logic mode_meta_reg;
    logic mode_sync_reg;

    // sleep and mode cross in through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
            mode_meta_reg  <= 1'b1;
            mode_sync_reg  <= 1'b1;
        end else begin
            sleep_meta_reg <= sleep_request;
            sleep_sync_reg <= sleep_meta_reg;
            mode_meta_reg  <= burst_order;
            mode_sync_reg  <= mode_meta_reg;
        end
    end

    // kept only for its two-flop shape; the pin path itself is async
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_meta_reg <= 1'b1;
            oe_sync_reg <= 1'b1;
        end else begin
            oe_meta_reg <= output_enable_n;
            oe_sync_reg <= oe_meta_reg;
        end
    end

    // --------------------------------------------------------------
    // write decode
    // --------------------------------------------------------------
    // any low select behind the gate, or global write, is a write
    function automatic logic [LANE_COUNT-1:0] lanes_of(
        input logic                  gw_n,
        input logic                  gate_n,
        input logic [LANE_COUNT-1:0] sel_n
    );
        lanes_of = {LANE_COUNT{1'b0}};
        for (int i = 0; i < LANE_COUNT; i++) begin
            lanes_of[i] = !gw_n || (!gate_n && !sel_n[i]);
        end
    endfunction

    logic [LANE_COUNT-1:0] lane_req;
    logic                  write_dec;
    assign lane_req  = lanes_of(global_write_n, byte_write_gate_n,
                                byte_select_n);
    assign write_dec = |lane_req;

    // --------------------------------------------------------------
    // cycle classification
    // --------------------------------------------------------------
    logic      selected;
    logic      proc_start;
    logic      ctrl_start;
    logic      burst_on;
    logic      in_sleep;
    logic      sleep_seen;
    cycle_type cycle_next;
    logic      load_addr;
    logic      step_addr;
    logic      write_next;
    logic      read_next;

    assign selected   = !select_low_first && select_high_second
                        && !select_low_third;
    // processor strobe is ignored while the first select is high
    assign proc_start = !processor_addr_strobe && !select_low_first;
    // controller strobe loses whenever processor strobe is low
    assign ctrl_start = !controller_addr_strobe
                        && processor_addr_strobe;

    always_comb begin
        cycle_next = CYC_IDLE;
        load_addr  = 1'b0;
        step_addr  = 1'b0;
        write_next = 1'b0;
        read_next  = 1'b0;
        if (sleep_seen) begin
            cycle_next = CYC_SLEEP;
        end else if (proc_start || ctrl_start) begin
            if (selected) begin
                cycle_next = CYC_BEGIN;
                load_addr  = 1'b1;
                // processor start never writes
                write_next = ctrl_start && write_dec;
                read_next  = !write_next;
            end else begin
                cycle_next = CYC_DESELECT;
            end
        end else if (controller_addr_strobe && burst_on
                     && (processor_addr_strobe || select_low_first)) begin
            if (!burst_advance) begin
                cycle_next = CYC_CONTINUE;
                step_addr  = 1'b1;
            end else begin
                cycle_next = CYC_SUSPEND;
            end
            write_next = write_dec;
            read_next  = !write_dec;
        end
    end

    // --------------------------------------------------------------
    // sleep entry and exit
    // --------------------------------------------------------------
    logic [1:0] sleep_cnt_reg;
    logic       sleep_reg;

    // two synchronised cycles at the new level change the state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_cnt_reg <= COUNT_RESET;
            sleep_reg     <= 1'b0;
        end else if (sleep_sync_reg == sleep_reg) begin
            sleep_cnt_reg <= COUNT_RESET;
        end else if (sleep_cnt_reg == SLEEP_CYCLES - 2'h1) begin
            sleep_reg     <= sleep_sync_reg;
            sleep_cnt_reg <= COUNT_RESET;
        end else begin
            sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
        end
    end

    // the pin floats the bus at once, before the state settles
    assign in_sleep = sleep_reg || sleep_request;
    // state logic only sees the synchronised pin, never the raw one
    assign sleep_seen = sleep_reg || sleep_sync_reg;

    // --------------------------------------------------------------
    // cycle state
    // --------------------------------------------------------------
    cycle_type cycle_reg;
    logic      burst_reg;
    logic      wr_cycle_reg;
    logic      rd_cycle_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cycle_reg    <= CYC_IDLE;
            wr_cycle_reg <= 1'b0;
            rd_cycle_reg <= 1'b0;
        end else begin
            cycle_reg    <= cycle_next;
            wr_cycle_reg <= write_next;
            rd_cycle_reg <= read_next;
        end
    end

    // a burst lives from a begin until deselect or sleep
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            burst_reg <= 1'b0;
        end else if (cycle_next == CYC_BEGIN) begin
            burst_reg <= 1'b1;
        end else if (cycle_next == CYC_DESELECT
                     || cycle_next == CYC_SLEEP) begin
            burst_reg <= 1'b0;
        end
    end
    assign burst_on = burst_reg;

    // --------------------------------------------------------------
    // address path
    // --------------------------------------------------------------
    logic [ADDR_WIDTH-1:0] base_reg;
    logic [BURST_BITS-1:0] burst_bits;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_reg <= {ADDR_WIDTH{1'b0}};
        end else if (load_addr) begin
            base_reg <= addr;
        end
    end

    burst_sequencer u_seq (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .load       (load_addr),
        .step       (step_addr),
        .interleave (mode_sync_reg),
        .start_bits (addr[BURST_BITS-1:0]),
        .burst_bits (burst_bits)
    );

    assign core_addr = {base_reg[ADDR_WIDTH-1:BURST_BITS], burst_bits};

    // --------------------------------------------------------------
    // write strobes and data
    // --------------------------------------------------------------
    logic [LANE_COUNT-1:0] lane_reg;
    logic [DATA_WIDTH-1:0] wdata_reg;

    // data and parity of a lane are written together
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_reg  <= {LANE_COUNT{1'b0}};
            wdata_reg <= {DATA_WIDTH{1'b0}};
        end else begin
            lane_reg  <= write_next ? lane_req : {LANE_COUNT{1'b0}};
            wdata_reg <= data_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANE_COUNT; g++) begin : g_lane
            assign write_data[g*LANE_WIDTH +: LANE_WIDTH] =
                wdata_reg[g*LANE_WIDTH +: LANE_WIDTH];
        end
    endgenerate
    assign lane_write = lane_reg;

    // --------------------------------------------------------------
    // data pin control
    // --------------------------------------------------------------
    logic [DATA_WIDTH-1:0] rdata_reg;

    // flow-through read data held in flops for the output path
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= {DATA_WIDTH{1'b0}};
        end else begin
            rdata_reg <= core_rdata;
        end
    end

    // live oe pin, masked in writes, deselect and sleep
    assign data_oe_n = !(rd_cycle_reg && !wr_cycle_reg && !in_sleep
                         && !output_enable_n);
    assign data_out    = rdata_reg;
    assign core_read   = rd_cycle_reg;
    assign cycle_state = cycle_reg;
    assign asleep      = sleep_reg;
endmodule
`default_nettype wire

// >>> pkg/burst_sram_pkg.sv
// constants and types for the burst sram cycle decoder
// assumes one 50 MHz clock and an active-low asynchronous reset
package burst_sram_pkg;
    localparam int LANE_COUNT = 4;
    localparam int LANE_WIDTH = 9;
    localparam int DATA_WIDTH = LANE_COUNT * LANE_WIDTH;
    localparam int ADDR_WIDTH = 21;
    localparam int BURST_BITS = 2;
    localparam logic [1:0] SLEEP_CYCLES = 2'h2;
    localparam logic [1:0] COUNT_RESET  = 2'h0;

    typedef enum logic [2:0] {
        CYC_IDLE     = 3'b000,
        CYC_DESELECT = 3'b001,
        CYC_SLEEP    = 3'b010,
        CYC_BEGIN    = 3'b011,
        CYC_CONTINUE = 3'b100,
        CYC_SUSPEND  = 3'b101
    } cycle_type;
endpackage
